// [shared/gpdi_consts.svh]
// Purpose: Offsets, field positions and reset values of the pin port block
// Assumes: Register index times four gives the APB byte address
// Notes:   Pin vectors pack port 0 in [7:0], port 1 in [15:8],
//          port 2 in [17:16] and port 3 in [19:18]
`ifndef GPDI_CONSTS_SVH
`define GPDI_CONSTS_SVH

// Register indices
`define GPDI_IDX_P0       8'h00
`define GPDI_IDX_P1       8'h01
`define GPDI_IDX_P2       8'h02
`define GPDI_IDX_P3       8'h03
`define GPDI_IDX_OE       8'h04
`define GPDI_IDX_OD       8'h05
`define GPDI_IDX_IEN      8'h06
`define GPDI_IDX_POL      8'h07
`define GPDI_IDX_STAT     8'h08
`define GPDI_IDX_MASK     8'h09
`define GPDI_IDX_ALT      8'h0A
`define GPDI_IDX_REGC     8'h0B
`define GPDI_IDX_USBC     8'h0C

// Reset values
`define GPDI_RST_PINS     20'h00000
`define GPDI_RST_IRQ      17'h00000
`define GPDI_RST_ALT      4'h0

// Control bit positions
`define GPDI_REGC_ON      0
`define GPDI_USBC_EN      7
`define GPDI_ALT_CLKO     0
`define GPDI_ALT_TMRA     1
`define GPDI_ALT_TMRB     2
`define GPDI_ALT_SPI      3

// Pin positions in the packed vector
`define GPDI_PIN_CLKI     0
`define GPDI_PIN_CLKO     1
`define GPDI_PIN_TMRA     5
`define GPDI_PIN_TMRB     6
`define GPDI_PIN_DP       8
`define GPDI_PIN_DM       9
`define GPDI_PIN_REGULATOR_OUT_PIN     10
`define GPDI_GRP_BIT      16

`endif

// [shared/gpdi_pkg.sv]
// Purpose: Types shared by the pin port block
// Assumes: Twenty physical pins over four ports
// Notes:   Constants live in gpdi_consts.svh
package gpdi_pkg;
    typedef logic [19:0] gpdi_pins_t;
    typedef logic [16:0] gpdi_irq_t;
    typedef logic [7:0]  gpdi_byte_t;
endpackage

// [core/gpdi_sync.sv]
// Purpose: Two flop synchroniser for all pin inputs
// Assumes: Pins may change at any time
// Notes:   First stage feeds only the second stage
`include "gpdi_consts.svh"
`timescale 1ns/1ps
module gpdi_sync (
    // Clock and reset
    input  wire logic               i_sys_clk,
    input  wire logic               i_rst,
    input  wire logic               i_clk_en,
    // Pins
    input  wire gpdi_pkg::gpdi_pins_t i_pin_in,
    output gpdi_pkg::gpdi_pins_t      o_pin_sync
);
    gpdi_pkg::gpdi_pins_t stage1;

    // Two stage capture
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            stage1     <= `GPDI_RST_PINS;
            o_pin_sync <= `GPDI_RST_PINS;
        end
        else if (i_clk_en)
        begin
            stage1     <= i_pin_in;
            o_pin_sync <= stage1;
        end
    end
endmodule // gpdi_sync

// [core/gpdi_edge.sv]
// Purpose: Edge detection of pin levels into interrupt events
// Assumes: Levels come from the synchroniser
// Notes:   Ports 2 and 3 share event bit 16
`include "gpdi_consts.svh"
`timescale 1ns/1ps
module gpdi_edge (
    // Clock and reset
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_rst,
    input  wire logic                 i_clk_en,
    // Pin levels and controls
    input  wire gpdi_pkg::gpdi_pins_t i_lvl,
    input  wire gpdi_pkg::gpdi_pins_t i_en,
    input  wire gpdi_pkg::gpdi_pins_t i_pol,
    // Events
    output gpdi_pkg::gpdi_irq_t       o_ev
);
    gpdi_pkg::gpdi_pins_t prev;
    gpdi_pkg::gpdi_pins_t hit;
    logic                 armed;
    logic                 grp_hit;
    logic                 grp_busy;

    // Qualifying transition per pin, falling when polarity set
    function automatic gpdi_pkg::gpdi_pins_t edge_hit(gpdi_pkg::gpdi_pins_t l,
        gpdi_pkg::gpdi_pins_t p, gpdi_pkg::gpdi_pins_t pl);
        return (pl & ~l & p) | (~pl & l & ~p);
    endfunction

    // Per pin hits and shared group state
    always_comb
    begin
        hit      = edge_hit(i_lvl, prev, i_pol);
        grp_hit  = |(hit[19:16] & i_en[19:16]);
        grp_busy = |((i_lvl[19:16] ^ i_pol[19:16]) & i_en[19:16]);
    end

    // Previous level and events
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            prev <= `GPDI_RST_PINS;
            o_ev <= `GPDI_RST_IRQ;
        end
        else if (i_clk_en)
        begin
            prev       <= i_lvl;
            o_ev[15:0] <= hit[15:0] & i_en[15:0];
            o_ev[16]   <= armed & grp_hit;
        end
    end

    // Shared source rearms only when every input is inactive
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            armed <= 1'b1;
        else if (i_clk_en)
        begin
            if (armed && grp_hit)
                armed <= 1'b0;
            else if (!armed && !grp_busy)
                armed <= 1'b1;
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    a_rise_event: assert property (i_clk_en && i_en[2] && !i_pol[2] && i_lvl[2] && !prev[2]
        |=> o_ev[2]) else $error("rising edge lost");
    a_fall_event: assert property (i_clk_en && i_en[2] && i_pol[2] && !i_lvl[2] && prev[2]
        |=> o_ev[2]) else $error("falling edge lost");
    a_group_once: assert property (i_clk_en && o_ev[16] |-> !armed)
        else $error("shared source still armed");
    c_group_ev: cover property (o_ev[16]);
endmodule // gpdi_edge

// [core/gpdi_port.sv]
// Purpose: Four pin ports with data, drive control and pin interrupts
// Assumes: APB slave, pins synchronous after two flops
// Notes:   Byte address is four times the register index
// Summary of operation
// - Written data drives output enabled pins
// - Data read returns sampled pin levels
// - Ports 2, 3 keep bits 1:0 only
// - Regulator enable takes port 1 pin 2
// - USB off: data bits drive pins 1:0
// - USB on: pins 1:0 are D- and D+
// - Regulator enable with USB on drives D-/D+ from data
// - Interrupt enable gates each pin event
// - Pin interrupts are edge triggered only
// - Shared source rearms when all inactive
// - Outputs toggled by firmware raise interrupts
// - Polarity set selects falling edge
// - Polarity clear selects rising edge
// - Port 0 timer, irq and clock functions
// - Port 1 bits 6:3 serve serial peripheral
// - Open drain floats ones, drives zeros
// - Driver enabled by output enable, except SPI pins (alt), USB pins and the regulator pin (off while regulator on)
`include "gpdi_consts.svh"
`timescale 1ns/1ps
module gpdi_port (
    // Clock and reset
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_rst,
    input  wire logic                 i_clk_en,
    // APB slave
    input  wire logic                 i_psel,
    input  wire logic                 i_penable,
    input  wire logic                 i_pwrite,
    input  wire logic [11:0]          i_paddr,
    input  wire logic [31:0]          i_pwdata,
    output logic      [31:0]          o_prdata,
    output logic                      o_pready,
    output logic                      o_pslverr,
    // Pins
    input  wire gpdi_pkg::gpdi_pins_t i_pin_in,
    output gpdi_pkg::gpdi_pins_t      o_pin_out,
    output gpdi_pkg::gpdi_pins_t      o_pin_oe,
    // Alternate function sources
    input  wire logic                 i_clock_out,
    input  wire logic [1:0]           i_timer_out,
    input  wire logic [3:0]           i_spi_out,
    input  wire logic [3:0]           i_spi_oe,
    input  wire logic [1:0]           i_usb_out,
    input  wire logic                 i_usb_oe,
    // Alternate function sinks
    output logic                      o_ext_clock_in,
    output logic [1:0]                o_timer_in,
    output logic [3:0]                o_spi_in,
    output logic [1:0]                o_usb_in,
    output logic [2:0]                o_ext_irq,
    output logic                      o_regulator_out_en,
    output logic                      o_usb_mode,
    // Interrupt
    output logic                      o_irq
);
    gpdi_pkg::gpdi_pins_t pin_s;
    gpdi_pkg::gpdi_pins_t data;
    gpdi_pkg::gpdi_pins_t oe_cfg;
    gpdi_pkg::gpdi_pins_t od_cfg;
    gpdi_pkg::gpdi_pins_t ien;
    gpdi_pkg::gpdi_pins_t pol;
    gpdi_pkg::gpdi_pins_t next_out;
    gpdi_pkg::gpdi_pins_t next_oe;
    gpdi_pkg::gpdi_irq_t  status;
    gpdi_pkg::gpdi_irq_t  mask;
    gpdi_pkg::gpdi_irq_t  ev;
    gpdi_pkg::gpdi_irq_t  clr;
    logic [3:0]           alt;
    logic                 reg_on;
    logic                 usb_en;
    logic [31:0]          next_rdata;
    logic                 mapped;
    logic [7:0]           idx;
    logic                 first_acc;
    logic                 wr_fire;

    // Port view of the packed pin vector, unused bits read as zero
    function automatic gpdi_pkg::gpdi_byte_t port_rd(gpdi_pkg::gpdi_pins_t v,
        logic [1:0] p);
        unique case (p)
            2'd0: return v[7:0];
            2'd1: return v[15:8];
            2'd2: return {6'h00, v[17:16]};
            2'd3: return {6'h00, v[19:18]};
        endcase
    endfunction

    // Port write into the packed pin vector
    function automatic gpdi_pkg::gpdi_pins_t port_wr(gpdi_pkg::gpdi_pins_t v,
        logic [1:0] p, gpdi_pkg::gpdi_byte_t b);
        gpdi_pkg::gpdi_pins_t r;
        r = v;
        unique case (p)
            2'd0: r[7:0]   = b;
            2'd1: r[15:8]  = b;
            2'd2: r[17:16] = b[1:0];
            2'd3: r[19:18] = b[1:0];
        endcase
        return r;
    endfunction

    // Pin synchroniser
    gpdi_sync u_sync (
        .i_sys_clk  (i_sys_clk),
        .i_rst      (i_rst),
        .i_clk_en   (i_clk_en),
        .i_pin_in   (i_pin_in),
        .o_pin_sync (pin_s)
    );

    // Edge detection
    gpdi_edge u_edge (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_clk_en  (i_clk_en),
        .i_lvl     (pin_s),
        .i_en      (ien),
        .i_pol     (pol),
        .o_ev      (ev)
    );

    // Bus decode
    always_comb
    begin
        idx       = i_paddr[9:2];
        mapped    = (i_paddr[11:10] == 2'b00) && (idx <= `GPDI_IDX_USBC);
        first_acc = i_clk_en && i_psel && i_penable && !o_pready;
        wr_fire   = i_clk_en && i_psel && i_penable && o_pready && i_pwrite && mapped;
    end

    // Read mux
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        case (idx)
            `GPDI_IDX_P0,
            `GPDI_IDX_P1,
            `GPDI_IDX_P2,
            `GPDI_IDX_P3:
                next_rdata[7:0] = port_rd(pin_s, idx[1:0]);
            `GPDI_IDX_OE:   next_rdata[19:0] = oe_cfg;
            `GPDI_IDX_OD:   next_rdata[19:0] = od_cfg;
            `GPDI_IDX_IEN:  next_rdata[19:0] = ien;
            `GPDI_IDX_POL:  next_rdata[19:0] = pol;
            `GPDI_IDX_STAT: next_rdata[16:0] = status;
            `GPDI_IDX_MASK: next_rdata[16:0] = mask;
            `GPDI_IDX_ALT:  next_rdata[3:0]  = alt;
            `GPDI_IDX_REGC: next_rdata[`GPDI_REGC_ON] = reg_on;
            `GPDI_IDX_USBC: next_rdata[`GPDI_USBC_EN] = usb_en;
            default:        next_rdata = 32'h0000_0000;
        endcase
    end

    // APB answer: one wait cycle, then ready with data
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end
        else if (i_clk_en)
        begin
            o_pready <= first_acc;
            if (first_acc)
            begin
                o_prdata  <= (i_pwrite || !mapped) ? 32'h0000_0000 : next_rdata;
                o_pslverr <= !mapped;
            end
        end
    end

    // Port data registers
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            data <= `GPDI_RST_PINS;
        else if (wr_fire && idx <= `GPDI_IDX_P3)
            data <= port_wr(data, idx[1:0], i_pwdata[7:0]);
    end

    // Pin configuration registers
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            oe_cfg <= `GPDI_RST_PINS;
            od_cfg <= `GPDI_RST_PINS;
            ien    <= `GPDI_RST_PINS;
            pol    <= `GPDI_RST_PINS;
        end
        else if (wr_fire)
        begin
            if (idx == `GPDI_IDX_OE)
                oe_cfg <= i_pwdata[19:0];
            if (idx == `GPDI_IDX_OD)
                od_cfg <= i_pwdata[19:0];
            if (idx == `GPDI_IDX_IEN)
                ien <= i_pwdata[19:0];
            if (idx == `GPDI_IDX_POL)
                pol <= i_pwdata[19:0];
        end
    end

    // Function select registers
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            alt    <= `GPDI_RST_ALT;
            reg_on <= 1'b0;
            usb_en <= 1'b0;
        end
        else if (wr_fire)
        begin
            if (idx == `GPDI_IDX_ALT)
                alt <= i_pwdata[3:0];
            if (idx == `GPDI_IDX_REGC)
                reg_on <= i_pwdata[`GPDI_REGC_ON];
            if (idx == `GPDI_IDX_USBC)
                usb_en <= i_pwdata[`GPDI_USBC_EN];
        end
    end

    // Sticky status, a new event wins over a write-one clear
    always_comb
    begin
        clr = (wr_fire && idx == `GPDI_IDX_STAT) ? i_pwdata[16:0] : `GPDI_RST_IRQ;
    end

    // Status and mask
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            status <= `GPDI_RST_IRQ;
            mask   <= `GPDI_RST_IRQ;
        end
        else if (i_clk_en)
        begin
            status <= (status & ~clr) | ev;
            if (wr_fire && idx == `GPDI_IDX_MASK)
                mask <= i_pwdata[16:0];
        end
    end

    // Pin drive selection
    always_comb
    begin
        next_oe  = oe_cfg & ~(od_cfg & data);
        next_out = data & ~od_cfg;
        if (alt[`GPDI_ALT_CLKO])
            next_out[`GPDI_PIN_CLKO] = i_clock_out;
        if (alt[`GPDI_ALT_TMRA])
            next_out[`GPDI_PIN_TMRA] = i_timer_out[0];
        if (alt[`GPDI_ALT_TMRB])
            next_out[`GPDI_PIN_TMRB] = i_timer_out[1];
        if (alt[`GPDI_ALT_SPI])
        begin
            next_out[14:11] = i_spi_out;
            next_oe[14:11]  = i_spi_oe;
        end
        if (reg_on)
        begin
            next_out[`GPDI_PIN_REGULATOR_OUT_PIN] = 1'b0;
            next_oe[`GPDI_PIN_REGULATOR_OUT_PIN]  = 1'b0;
        end
        if (usb_en && reg_on)
        begin
            next_out[9:8] = data[9:8];
            next_oe[9:8]  = 2'b11;
        end
        else if (usb_en)
        begin
            next_out[9:8] = i_usb_out;
            next_oe[9:8]  = {2{i_usb_oe}};
        end
    end

    // Registered outputs
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_pin_out          <= `GPDI_RST_PINS;
            o_pin_oe           <= `GPDI_RST_PINS;
            o_ext_irq          <= 3'h0;
            o_regulator_out_en <= 1'b0;
            o_usb_mode         <= 1'b0;
            o_irq              <= 1'b0;
        end
        else if (i_clk_en)
        begin
            o_pin_out          <= next_out;
            o_pin_oe           <= next_oe;
            o_ext_irq          <= ev[4:2];
            o_regulator_out_en <= reg_on;
            o_usb_mode         <= usb_en;
            o_irq              <= |(status & mask);
        end
    end

    // Inputs to alternate functions
    always_comb
    begin
        o_ext_clock_in = pin_s[`GPDI_PIN_CLKI];
        o_timer_in     = {pin_s[`GPDI_PIN_TMRB], pin_s[`GPDI_PIN_TMRA]};
        o_spi_in       = pin_s[14:11];
        o_usb_in       = pin_s[9:8];
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    a_wr_data_store: assert property (wr_fire && idx == `GPDI_IDX_P1
        |=> data[15:8] == $past(i_pwdata[7:0])) else $error("port write lost");
    a_rd_pin_level: assert property (first_acc && !i_pwrite && mapped && idx == `GPDI_IDX_P0
        |=> o_pready && o_prdata[7:0] == $past(pin_s[7:0]))
        else $error("read not pin level");
    a_rsvd_zero: assert property (first_acc && !i_pwrite && idx == `GPDI_IDX_P3
        |=> o_prdata[31:2] == 30'h0) else $error("reserved bits set");
    a_regulator_out_pin_pin_off: assert property (i_clk_en && reg_on
        |=> !o_pin_oe[`GPDI_PIN_REGULATOR_OUT_PIN] && o_regulator_out_en)
        else $error("regulator pin still driven");
    a_usb_gpio: assert property (i_clk_en && !usb_en && !od_cfg[8]
        |=> o_pin_out[8] == $past(data[8])) else $error("D+ pin not data");
    a_usb_force: assert property (i_clk_en && usb_en && reg_on
        |=> o_pin_oe[9:8] == 2'b11 && o_pin_out[9:8] == $past(data[9:8]))
        else $error("forced bus state wrong");
    a_od_float: assert property (i_clk_en && od_cfg[0] && data[0]
        |=> !o_pin_oe[0]) else $error("open drain one driven");
    a_oe_off: assert property (i_clk_en && !oe_cfg[7]
        |=> !o_pin_oe[7]) else $error("driver on without enable");
    a_status_sticky: assert property (i_clk_en && ev[3]
        |=> status[3] ##1 (status[3] || $past(clr[3])))
        else $error("event not held");
    a_irq_level: assert property (i_clk_en && (status & mask) != `GPDI_RST_IRQ
        |=> o_irq) else $error("interrupt not raised");

    c_port_write: cover property (wr_fire && idx == `GPDI_IDX_P0);
    c_irq_rise: cover property (!o_irq ##1 o_irq);
    c_usb_mode: cover property (usb_en && !reg_on ##1 o_pin_oe[9:8] == 2'b11);
endmodule // gpdi_port

// [test/gpdi_board.sv]
// Purpose: Board model that settles each port pin to one level
// Assumes: Device drive wins over the bench's own source on a pin
// Notes:   Undriven pins sit on a weak pull-down to ground
`timescale 1ns/1ps
module gpdi_board (
    // Device side
    input  wire gpdi_pkg::gpdi_pins_t i_pin_out,
    input  wire gpdi_pkg::gpdi_pins_t i_pin_oe,
    // Bench sources
    input  wire gpdi_pkg::gpdi_pins_t i_ext_val,
    input  wire gpdi_pkg::gpdi_pins_t i_ext_en,
    // Settled levels
    output gpdi_pkg::gpdi_pins_t      o_pin_lvl
);
    // Driven pins show the device, others the bench or the pull-down
    assign o_pin_lvl = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_en & i_ext_val);
endmodule // gpdi_board

// [test/testbench.sv]
// Purpose: Register level regression of the pin port block
// Assumes: APB answer within 20 cycles; pin to status takes 4 edges
// Notes:   Byte address is four times the register index
`include "gpdi_consts.svh"
`timescale 1ns/1ps
module testbench;
    logic                 i_sys_clk = 1'b0;
    logic                 i_rst = 1'b1;
    logic                 psel, penable, pwrite, pready, pslverr, irq, clk_in, usb_mode;
    logic                 clock_out, usb_oe, reg_en, err;
    logic [11:0]          paddr;
    logic [31:0]          pwdata, prdata, rdata;
    logic [1:0]           timer_out, usb_out, timer_in, usb_in;
    logic [3:0]           spi_out, spi_oe, spi_in;
    logic [2:0]           ext_irq;
    gpdi_pkg::gpdi_pins_t pin_in, pin_out, pin_oe, ext_val, ext_en;
    int                   fails, n_compared, n_eirq;

    // Clock of 25 ns period
    always #12.5 i_sys_clk = ~i_sys_clk;

    // Count event pulses of the first external interrupt pin
    always @(posedge i_sys_clk) if (ext_irq[0] === 1'b1) n_eirq++;

    gpdi_board board (.i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_ext_val(ext_val),
        .i_ext_en(ext_en), .o_pin_lvl(pin_in));

    gpdi_port dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_en(1'b1), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_pin_in(pin_in),
        .o_pin_out(pin_out), .o_pin_oe(pin_oe), .i_clock_out(clock_out),
        .i_timer_out(timer_out), .i_spi_out(spi_out), .i_spi_oe(spi_oe),
        .i_usb_out(usb_out), .i_usb_oe(usb_oe), .o_ext_clock_in(clk_in), .o_timer_in(timer_in),
        .o_spi_in(spi_in), .o_usb_in(usb_in), .o_ext_irq(ext_irq), .o_regulator_out_en(reg_en),
        .o_usb_mode(usb_mode), .o_irq(irq));

    // Prints counts and verdict, then stops
    task print_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Compares one value with its expectation
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; holds the request until pready is sampled high
    task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int k;
        @(posedge i_sys_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= wd;
        @(posedge i_sys_clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge i_sys_clk);
            if (pready === 1'b1) break;
        end
        rdata   = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k == 20)
        begin
            fails++;
            print_verdict();
        end
    endtask

    task wr(input logic [7:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd);
    endtask

    task rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        check(rdata, exp);
    endtask

    task wt(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask

    // Main sequence
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, clock_out, timer_out} = '0;
        {spi_out, spi_oe, usb_out, usb_oe, ext_val, ext_en} = '0;
        wt(4);
        i_rst <= 1'b0;
        for (int i = 0; i < 4; i++) rd_chk(8'(i), 32'h0);
        apb(1'b0, 8'h0D, 32'h0);
        check(32'(err), 32'h1);
        $display("Test reset and decode done");
        // Drive and read back the data registers
        wr(`GPDI_IDX_OE, 32'h000FFFFF);
        wr(`GPDI_IDX_P0, 32'hFFFFFFA5);
        wr(`GPDI_IDX_P1, 32'h0000005A);
        wr(`GPDI_IDX_P2, 32'h000000FF);
        wr(`GPDI_IDX_P3, 32'h000000FE);
        wt(3);
        check(32'(pin_out[15:0]), 32'h5AA5);
        rd_chk(`GPDI_IDX_P0, 32'hA5);
        rd_chk(`GPDI_IDX_P2, 32'h03);
        rd_chk(`GPDI_IDX_P3, 32'h02);
        // Disabled drivers: reads follow the board, not written data
        ext_en  <= 20'hFFFFF;
        ext_val <= 20'h0003C;
        wr(`GPDI_IDX_OE, 32'h0);
        wt(4);
        check(32'(pin_oe), 32'h0);
        rd_chk(`GPDI_IDX_P0, 32'h3C);
        $display("Test data path done");
        // Open drain floats ones and pulls zeros low
        wr(`GPDI_IDX_OE, 32'hFF);
        wr(`GPDI_IDX_OD, 32'hFF);
        wr(`GPDI_IDX_P0, 32'h0F);
        wt(3);
        check({16'h0, pin_oe[7:0], pin_out[7:0]}, 32'hF000);
        wr(`GPDI_IDX_OD, 32'h0);
        wr(`GPDI_IDX_OE, 32'h0);
        ext_val <= 20'h0;
        wr(`GPDI_IDX_MASK, 32'h1FFFF);
        // Both edge polarities on an external interrupt pin
        for (int p = 0; p < 2; p++)
        begin
            wr(`GPDI_IDX_IEN, 32'h4);
            wr(`GPDI_IDX_POL, p ? 32'h4 : 32'h0);
            ext_val[2] <= p[0];
            wt(6);
            wr(`GPDI_IDX_STAT, 32'h1FFFF);
            n_eirq = 0;
            ext_val[2] <= ~p[0];
            wt(6);
            rd_chk(`GPDI_IDX_STAT, 32'h4);
            check(32'(irq), 32'h1);
            check(32'(n_eirq), 32'h1);
            wr(`GPDI_IDX_STAT, 32'h4);
            wt(3);
            rd_chk(`GPDI_IDX_STAT, 32'h0);
            check(32'(irq), 32'h0);
        end
        // Disabled pin raises nothing; masked event only sets status
        wr(`GPDI_IDX_POL, 32'h0);
        wr(`GPDI_IDX_IEN, 32'h0);
        ext_val[2] <= 1'b0;
        wt(6);
        ext_val[2] <= 1'b1;
        wt(6);
        rd_chk(`GPDI_IDX_STAT, 32'h0);
        wr(`GPDI_IDX_IEN, 32'h4);
        ext_val[2] <= 1'b0;
        wr(`GPDI_IDX_MASK, 32'h0);
        ext_val[2] <= 1'b1;
        wt(6);
        rd_chk(`GPDI_IDX_STAT, 32'h4);
        check(32'(irq), 32'h0);
        wr(`GPDI_IDX_MASK, 32'h1FFFF);
        wt(2);
        check(32'(irq), 32'h1);
        wr(`GPDI_IDX_STAT, 32'h4);
        $display("Test pin interrupts done");
        // Firmware raises an interrupt on an output pin
        wr(`GPDI_IDX_P0, 32'h0);
        wr(`GPDI_IDX_OE, 32'h8);
        wr(`GPDI_IDX_IEN, 32'h8);
        wt(6);
        wr(`GPDI_IDX_STAT, 32'h1FFFF);
        wr(`GPDI_IDX_P0, 32'h8);
        wt(7);
        rd_chk(`GPDI_IDX_STAT, 32'h8);
        // Shared source waits until all its pins are inactive
        wr(`GPDI_IDX_OE, 32'h0);
        wr(`GPDI_IDX_IEN, 32'h50000);
        wr(`GPDI_IDX_STAT, 32'h1FFFF);
        ext_val[16] <= 1'b1;
        wt(6);
        rd_chk(`GPDI_IDX_STAT, 32'h10000);
        wr(`GPDI_IDX_STAT, 32'h10000);
        ext_val[18] <= 1'b1;
        wt(6);
        rd_chk(`GPDI_IDX_STAT, 32'h0);
        ext_val[16] <= 1'b0;
        ext_val[18] <= 1'b0;
        wt(6);
        ext_val[18] <= 1'b1;
        wt(6);
        rd_chk(`GPDI_IDX_STAT, 32'h10000);
        $display("Test shared interrupt done");
        // Regulator and USB ownership of port 1 pins 2:0
        wr(`GPDI_IDX_OE, 32'h700);
        wr(`GPDI_IDX_P1, 32'h06);
        wt(3);
        check({26'h0, pin_oe[10:8], pin_out[10:8]}, 32'h3E);
        wr(`GPDI_IDX_REGC, 32'h1);
        wt(3);
        check({30'h0, reg_en, pin_oe[10]}, 32'h2);
        wr(`GPDI_IDX_REGC, 32'h0);
        usb_out <= 2'b01;
        usb_oe  <= 1'b1;
        wr(`GPDI_IDX_USBC, 32'h80);
        wt(3);
        check({29'h0, usb_mode, pin_out[9:8]}, 32'h5);
        wr(`GPDI_IDX_REGC, 32'h1);
        wt(3);
        check({28'h0, pin_oe[9:8], pin_out[9:8]}, 32'hE);
        $display("Test regulator and USB done");
        // Alternate drive of clock, timer and serial pins
        wr(`GPDI_IDX_USBC, 32'h0);
        wr(`GPDI_IDX_REGC, 32'h0);
        wr(`GPDI_IDX_OE, 32'h22);
        clock_out <= 1'b1;
        timer_out <= 2'b01;
        spi_out   <= 4'hA;
        spi_oe    <= 4'hF;
        ext_val[0] <= 1'b1;
        wr(`GPDI_IDX_ALT, 32'hB);
        wt(4);
        check({22'h0, pin_out[14:11], pin_oe[14:11], pin_out[5], pin_out[1]}, 32'h2BF);
        check(32'(clk_in), 32'h1);
        check({24'h0, usb_in, timer_in, spi_in}, 32'h1A);
        $display("Test alternate functions done");
        print_verdict();
    end
endmodule // testbench
